// *** core/adccal_regs.sv ***
// Channel 1 gain trim and channel 2 setup/trim registers on AXI4-Lite.
// Assumes one clock, synchronous active-low reset, well-behaved master.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/10ps

// What this block does
// RULE_01: The channel 1 gain upper word holds gain bits 23:8, read/write.
// RULE_02: Channel 1 gain lower register bits 15:8 hold gain bits 7:0, read/write, reset zero.
// RULE_03: The channel 1 gain upper word at index 11h resets to 8000h.
// RULE_04: The channel 2 gain upper word at index 16h resets to 8000h.
// RULE_05: Channel 2 setup bits 15:6 hold a 10-bit two's complement delay, reset zero.
// RULE_06: Channel 2 setup bit 2 set turns off the channel 2 high-pass filter.
// RULE_07: With that bit clear, the global high-pass setting governs channel 2.
// RULE_08: Channel 2 select 00 external, 01 shorted, 10 positive test, 11 negative test.
// RULE_09: The channel 2 offset upper word holds offset bits 23:8, read/write, reset zero.
// RULE_10: Channel 2 offset lower register bits 15:8 hold offset bits 7:0, reset zero.
// RULE_11: Reserved bits ignore writes and read as zero.
module adccal_regs (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [3:0] global_highpass_setting,
  output logic [23:0] ch1_gain_value,
  output logic [23:0] ch2_offset_value,
  output logic [15:0] ch2_gain_value_upper,
  output logic [9:0] ch2_delay_trim,
  output logic ch2_filter_enable,
  output logic [3:0] ch2_highpass_setting,
  output logic [3:0] ch2_path_onehot
);

  logic [15:0] regs_q [0:5];
  logic wr_en;
  logic [7:0] wr_addr;
  logic [15:0] wr_data;
  logic [1:0] wr_strb;
  logic wr_err;
  logic [15:0] byte_mask;
  logic [15:0] status_word;
  logic [15:0] rd_word;
  logic rd_hit;
  logic ar_hs;
  logic [15:0] ch1_gain_trim_high;
  logic [15:0] ch1_gain_trim_low;
  logic [15:0] ch2_channel_setup;
  logic [15:0] ch2_offset_trim_high;
  logic [15:0] ch2_offset_trim_low;
  logic [15:0] ch2_gain_trim_high;
  logic [15:0] ch1_gain_value_upper;
  logic [7:0] ch1_gain_value_lower;
  logic [15:0] ch2_offset_value_upper;
  logic [7:0] ch2_offset_value_lower;
  logic [1:0] ch2_input_select;
  logic ch2_highpass_off;

  // ==========================================================
  // Write channel
  adccal_wr_capture u_wr (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err)
  );

  // Unmapped writes answer SLVERR; status writes are dropped quietly
  always_comb begin
    wr_err = (wr_addr[7:2] != adccal_pkg::IDX_STATUS[5:0]);
    for (int k = 0; k < adccal_pkg::NREG; k++) begin
      if (wr_addr[7:2] == adccal_pkg::REG_IDX[k][5:0]) begin
        wr_err = 1'b0;
      end
    end
  end

  assign byte_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};

  // ==========================================================
  // Register storage
  for (genvar i = 0; i < adccal_pkg::NREG; i++) begin : g_reg
    logic [15:0] upd_mask;
    assign upd_mask = byte_mask & adccal_pkg::REG_WMASK[i]; // RULE_11
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        regs_q[i] <= adccal_pkg::REG_RST[i]; // RULE_03 RULE_04
      end else if (wr_en && wr_addr[7:2] == adccal_pkg::REG_IDX[i][5:0]) begin
        regs_q[i] <= (regs_q[i] & ~upd_mask) | (wr_data & upd_mask); // RULE_01 RULE_02 RULE_09 RULE_10
      end
    end
  end

  assign ch1_gain_trim_high = regs_q[adccal_pkg::SLOT_CH1_GAIN_HIGH];
  assign ch1_gain_trim_low = regs_q[adccal_pkg::SLOT_CH1_GAIN_LOW];
  assign ch2_channel_setup = regs_q[adccal_pkg::SLOT_CH2_SETUP];
  assign ch2_offset_trim_high = regs_q[adccal_pkg::SLOT_CH2_OFFSET_HIGH];
  assign ch2_offset_trim_low = regs_q[adccal_pkg::SLOT_CH2_OFFSET_LOW];
  assign ch2_gain_trim_high = regs_q[adccal_pkg::SLOT_CH2_GAIN_HIGH];

  // ==========================================================
  // Fields to the datapath
  assign ch1_gain_value_upper = ch1_gain_trim_high;
  assign ch1_gain_value_lower = ch1_gain_trim_low[adccal_pkg::LOW_MSB:adccal_pkg::LOW_LSB];
  assign ch1_gain_value = {ch1_gain_value_upper, ch1_gain_value_lower}; // RULE_01 RULE_02
  assign ch2_offset_value_upper = ch2_offset_trim_high;
  assign ch2_offset_value_lower = ch2_offset_trim_low[adccal_pkg::LOW_MSB:adccal_pkg::LOW_LSB];
  assign ch2_offset_value = {ch2_offset_value_upper, ch2_offset_value_lower}; // RULE_09 RULE_10
  assign ch2_gain_value_upper = ch2_gain_trim_high; // RULE_04
  assign ch2_delay_trim = ch2_channel_setup[adccal_pkg::DELAY_MSB:adccal_pkg::DELAY_LSB]; // RULE_05
  assign ch2_highpass_off = ch2_channel_setup[adccal_pkg::HPOFF_BIT];
  assign ch2_input_select = ch2_channel_setup[adccal_pkg::SEL_MSB:adccal_pkg::SEL_LSB];

  adccal_ch2_route u_route (
    .aclk(aclk),
    .aresetn(aresetn),
    .ch2_input_select(ch2_input_select),
    .ch2_highpass_off(ch2_highpass_off),
    .global_highpass_setting(global_highpass_setting),
    .ch2_filter_enable(ch2_filter_enable),
    .ch2_highpass_setting(ch2_highpass_setting),
    .ch2_path_onehot(ch2_path_onehot)
  );

  // Live channel 2 state: bit 4 filter on, bits 3:0 input path
  assign status_word = {11'h000, ch2_filter_enable, ch2_path_onehot};

  // ==========================================================
  // Read channel
  always_comb begin
    rd_hit = 1'b0;
    rd_word = 16'h0000;
    for (int k = 0; k < adccal_pkg::NREG; k++) begin
      if (araddr[7:2] == adccal_pkg::REG_IDX[k][5:0]) begin
        rd_hit = 1'b1;
        rd_word = regs_q[k];
      end
    end
    if (araddr[7:2] == adccal_pkg::IDX_STATUS[5:0]) begin
      rd_hit = 1'b1;
      rd_word = status_word;
    end
  end

  assign arready = !rvalid;
  assign ar_hs = arvalid && arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
    end else if (ar_hs) begin
      rvalid <= 1'b1;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata <= 32'h00000000;
      rresp <= adccal_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      rdata <= {16'h0000, rd_word}; // RULE_11
      rresp <= rd_hit ? adccal_pkg::RESP_OKAY : adccal_pkg::RESP_SLVERR;
    end
  end

  // ==========================================================
  // Assertions
  ch1_high_reset_a: assert property (@(posedge aclk) $rose(aresetn) |-> // RULE_03
    ch1_gain_value_upper == adccal_pkg::GAIN_HIGH_RST)
    else $error("ch1 gain upper word not 8000h after reset");

  ch2_high_reset_a: assert property (@(posedge aclk) $rose(aresetn) |-> // RULE_04
    ch2_gain_value_upper == adccal_pkg::GAIN_HIGH_RST && ch2_delay_trim == 10'h000)
    else $error("ch2 gain upper word or delay wrong after reset");

  ch1_high_write_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_01
    wr_en && wr_addr == adccal_pkg::ADDR_CH1_GAIN_TRIM_HIGH && wr_strb == 2'h3
    |=> ch1_gain_value[23:8] == $past(wr_data))
    else $error("ch1 gain upper word did not take write");

  ch1_low_write_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_02
    wr_en && wr_addr == adccal_pkg::ADDR_CH1_GAIN_TRIM_LOW && wr_strb[1]
    |=> ch1_gain_value[7:0] == $past(wr_data[15:8]))
    else $error("ch1 gain lower byte did not take write");

  ch2_delay_write_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_05
    wr_en && wr_addr == adccal_pkg::ADDR_CH2_CHANNEL_SETUP && wr_strb == 2'h3
    |=> ch2_delay_trim == $past(wr_data[15:6]) ##1 ch2_path_onehot == 4'h1 << $past(wr_data[1:0], 2))
    else $error("ch2 delay or input path does not follow setup write");

  hp_off_wins_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_06
    ch2_highpass_off |=> !ch2_filter_enable && ch2_highpass_setting == 4'h0)
    else $error("ch2 filter on while local disable set");

  hp_global_follow_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_07
    !ch2_highpass_off |=> ch2_highpass_setting == $past(global_highpass_setting)
    && ch2_filter_enable == ($past(global_highpass_setting) != 4'h0))
    else $error("ch2 filter ignores global setting");

  path_decode_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_08
    ch2_input_select == 2'h3 |=> ch2_path_onehot == 4'h8)
    else $error("negative test select not decoded");

  ch2_offset_write_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_09
    wr_en && wr_addr == adccal_pkg::ADDR_CH2_OFFSET_TRIM_HIGH && wr_strb == 2'h3
    |=> ch2_offset_value[23:8] == $past(wr_data))
    else $error("ch2 offset upper word did not take write");

  ch2_offset_low_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_10
    wr_en && wr_addr == adccal_pkg::ADDR_CH2_OFFSET_TRIM_LOW && wr_strb[1]
    |=> ch2_offset_value[7:0] == $past(wr_data[15:8]))
    else $error("ch2 offset lower byte did not take write");

  reserved_zero_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_11
    ch1_gain_trim_low[7:0] == 8'h00 && ch2_offset_trim_low[7:0] == 8'h00
    && ch2_channel_setup[5:3] == 3'h0)
    else $error("reserved bits not zero");

  read_back_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_hs && araddr == adccal_pkg::ADDR_CH1_GAIN_TRIM_HIGH
    |=> rvalid && rresp == adccal_pkg::RESP_OKAY && rdata == {16'h0000, $past(ch1_gain_trim_high)})
    else $error("read of ch1 gain upper word wrong");

  write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_en |=> bvalid)
    else $error("write response not raised after write");

  ch2_gain_write_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_04
    wr_en && wr_addr == adccal_pkg::ADDR_CH2_GAIN_TRIM_HIGH && wr_strb == 2'h3
    |=> ch2_gain_value_upper == $past(wr_data))
    else $error("ch2 gain upper word did not take write");

  trim_reset_a: assert property (@(posedge aclk) $rose(aresetn) |-> // RULE_02 RULE_09 RULE_10
    ch2_offset_value == 24'h000000 && ch1_gain_value[7:0] == 8'h00)
    else $error("trim values not zero after reset");

  bad_write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_en && wr_err |=> bvalid && bresp == adccal_pkg::RESP_SLVERR)
    else $error("unmapped write not refused");

  bad_read_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_hs && !rd_hit |=> rvalid && rresp == adccal_pkg::RESP_SLVERR && rdata == 32'h00000000)
    else $error("unmapped read not refused");

  status_read_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_06 RULE_08
    ar_hs && araddr[7:2] == adccal_pkg::IDX_STATUS[5:0]
    |=> rresp == adccal_pkg::RESP_OKAY && rdata == {16'h0000, $past(status_word)})
    else $error("status read does not show live channel 2 state");

  wr_busy_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bvalid |-> !awready && !wready)
    else $error("write channel open while response pending");

  path_external_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_08
    ch2_input_select == 2'h0 |=> ch2_path_onehot == 4'h1)
    else $error("external select not decoded");

  path_shorted_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_08
    ch2_input_select == 2'h1 |=> ch2_path_onehot == 4'h2)
    else $error("shorted select not decoded");

  path_test_pos_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_08
    ch2_input_select == 2'h2 |=> ch2_path_onehot == 4'h4)
    else $error("positive test select not decoded");

  bad_write_c: cover property (@(posedge aclk) disable iff (!aresetn)
    wr_en && wr_err);

  both_write_c: cover property (@(posedge aclk) disable iff (!aresetn)
    awvalid && awready && wvalid && wready);

  addr_first_c: cover property (@(posedge aclk) disable iff (!aresetn)
    awvalid && awready && !wvalid ##[1:4] wvalid && wready);

  status_read_c: cover property (@(posedge aclk) disable iff (!aresetn)
    ar_hs && araddr == adccal_pkg::ADDR_STATUS);

  test_neg_c: cover property (@(posedge aclk) disable iff (!aresetn)
    ch2_path_onehot == 4'h8 && !ch2_filter_enable);

endmodule // adccal_regs

// *** core/adccal_pkg.sv ***
// Constants for the channel trim and setup register slice.
// Assumes a 32-bit AXI4-Lite slave with 8-bit byte addresses.
package adccal_pkg;

  // ==========================================================
  // Bus
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned NREG = 6;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CH1_GAIN_TRIM_HIGH = 8'h11;
  localparam logic [7:0] IDX_CH1_GAIN_TRIM_LOW = 8'h12;
  localparam logic [7:0] IDX_CH2_CHANNEL_SETUP = 8'h13;
  localparam logic [7:0] IDX_CH2_OFFSET_TRIM_HIGH = 8'h14;
  localparam logic [7:0] IDX_CH2_OFFSET_TRIM_LOW = 8'h15;
  localparam logic [7:0] IDX_CH2_GAIN_TRIM_HIGH = 8'h16;
  localparam logic [7:0] IDX_STATUS = 8'h20;
  localparam logic [7:0] ADDR_CH1_GAIN_TRIM_HIGH = {IDX_CH1_GAIN_TRIM_HIGH[5:0], 2'h0};
  localparam logic [7:0] ADDR_CH1_GAIN_TRIM_LOW = {IDX_CH1_GAIN_TRIM_LOW[5:0], 2'h0};
  localparam logic [7:0] ADDR_CH2_CHANNEL_SETUP = {IDX_CH2_CHANNEL_SETUP[5:0], 2'h0};
  localparam logic [7:0] ADDR_CH2_OFFSET_TRIM_HIGH = {IDX_CH2_OFFSET_TRIM_HIGH[5:0], 2'h0};
  localparam logic [7:0] ADDR_CH2_OFFSET_TRIM_LOW = {IDX_CH2_OFFSET_TRIM_LOW[5:0], 2'h0};
  localparam logic [7:0] ADDR_CH2_GAIN_TRIM_HIGH = {IDX_CH2_GAIN_TRIM_HIGH[5:0], 2'h0};
  localparam logic [7:0] ADDR_STATUS = {IDX_STATUS[5:0], 2'h0};

  // ==========================================================
  // Storage slots, reset values and writable bits
  localparam int unsigned SLOT_CH1_GAIN_HIGH = 0;
  localparam int unsigned SLOT_CH1_GAIN_LOW = 1;
  localparam int unsigned SLOT_CH2_SETUP = 2;
  localparam int unsigned SLOT_CH2_OFFSET_HIGH = 3;
  localparam int unsigned SLOT_CH2_OFFSET_LOW = 4;
  localparam int unsigned SLOT_CH2_GAIN_HIGH = 5;
  localparam logic [15:0] GAIN_HIGH_RST = 16'h8000;
  localparam logic [15:0] ZERO_RST = 16'h0000;
  localparam logic [15:0] FULL_WMASK = 16'hffff;
  localparam logic [15:0] LOW_WMASK = 16'hff00;
  localparam logic [15:0] SETUP_WMASK = 16'hffc7;
  localparam logic [7:0] REG_IDX [0:5] = '{IDX_CH1_GAIN_TRIM_HIGH, IDX_CH1_GAIN_TRIM_LOW,
    IDX_CH2_CHANNEL_SETUP, IDX_CH2_OFFSET_TRIM_HIGH, IDX_CH2_OFFSET_TRIM_LOW, IDX_CH2_GAIN_TRIM_HIGH};
  localparam logic [15:0] REG_RST [0:5] = '{GAIN_HIGH_RST, ZERO_RST, ZERO_RST, ZERO_RST,
    ZERO_RST, GAIN_HIGH_RST};
  localparam logic [15:0] REG_WMASK [0:5] = '{FULL_WMASK, LOW_WMASK, SETUP_WMASK, FULL_WMASK,
    LOW_WMASK, FULL_WMASK};

  // ==========================================================
  // Field positions
  localparam int unsigned LOW_MSB = 15;
  localparam int unsigned LOW_LSB = 8;
  localparam int unsigned DELAY_MSB = 15;
  localparam int unsigned DELAY_LSB = 6;
  localparam int unsigned HPOFF_BIT = 2;
  localparam int unsigned SEL_MSB = 1;
  localparam int unsigned SEL_LSB = 0;
  localparam logic [3:0] HP_GLOBAL_OFF = 4'h0;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    SEL_EXTERNAL = 2'h0,
    SEL_SHORTED = 2'h1,
    SEL_TEST_POS = 2'h2,
    SEL_TEST_NEG = 2'h3
  } adccal_sel_t;

  typedef enum logic [4:0] {
    WR_IDLE = 5'h01,
    WR_GOT_ADDR = 5'h02,
    WR_GOT_DATA = 5'h04,
    WR_EXEC = 5'h08,
    WR_RESP = 5'h10
  } adccal_wr_state_t;

endpackage

// *** core/adccal_wr_capture.sv ***
// AXI4-Lite write channel capture: takes address and data in any order.
// Assumes the parent answers wr_err combinationally from wr_addr.
`timescale 1ns/10ps
module adccal_wr_capture (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [15:0] wr_data,
  output logic [1:0] wr_strb,
  input wire logic wr_err
);

  adccal_pkg::adccal_wr_state_t state_q;
  logic aw_hs;
  logic w_hs;

  // ==========================================================
  // Handshakes
  assign awready = (state_q == adccal_pkg::WR_IDLE) || (state_q == adccal_pkg::WR_GOT_DATA);
  assign wready = (state_q == adccal_pkg::WR_IDLE) || (state_q == adccal_pkg::WR_GOT_ADDR);
  assign aw_hs = awvalid && awready;
  assign w_hs = wvalid && wready;
  assign wr_en = (state_q == adccal_pkg::WR_EXEC);
  assign bvalid = (state_q == adccal_pkg::WR_RESP);

  // ==========================================================
  // Sequencing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= adccal_pkg::WR_IDLE;
    end else begin
      case (state_q)
        adccal_pkg::WR_IDLE: begin
          if (aw_hs && w_hs) begin
            state_q <= adccal_pkg::WR_EXEC;
          end else if (aw_hs) begin
            state_q <= adccal_pkg::WR_GOT_ADDR;
          end else if (w_hs) begin
            state_q <= adccal_pkg::WR_GOT_DATA;
          end
        end
        adccal_pkg::WR_GOT_ADDR: begin
          if (w_hs) begin
            state_q <= adccal_pkg::WR_EXEC;
          end
        end
        adccal_pkg::WR_GOT_DATA: begin
          if (aw_hs) begin
            state_q <= adccal_pkg::WR_EXEC;
          end
        end
        adccal_pkg::WR_EXEC: state_q <= adccal_pkg::WR_RESP;
        adccal_pkg::WR_RESP: begin
          if (bready) begin
            state_q <= adccal_pkg::WR_IDLE;
          end
        end
        default: state_q <= adccal_pkg::WR_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Captured payload and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_addr <= 8'h00;
      wr_data <= 16'h0000;
      wr_strb <= 2'h0;
      bresp <= adccal_pkg::RESP_OKAY;
    end else begin
      if (aw_hs) begin
        wr_addr <= awaddr;
      end
      if (w_hs) begin
        wr_data <= wdata[15:0];
        wr_strb <= wstrb[1:0];
      end
      if (wr_en) begin
        bresp <= wr_err ? adccal_pkg::RESP_SLVERR : adccal_pkg::RESP_OKAY;
      end
    end
  end

endmodule // adccal_wr_capture

// *** core/adccal_ch2_route.sv ***
// Channel 2 input path and high-pass filter steering.
// Assumes setup fields come straight from the register flops.
`timescale 1ns/10ps
module adccal_ch2_route (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] ch2_input_select,
  input wire logic ch2_highpass_off,
  input wire logic [3:0] global_highpass_setting,
  output logic ch2_filter_enable,
  output logic [3:0] ch2_highpass_setting,
  output logic [3:0] ch2_path_onehot
);

  // ==========================================================
  // Filter: local disable overrides the global setting
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ch2_filter_enable <= 1'b0;
      ch2_highpass_setting <= adccal_pkg::HP_GLOBAL_OFF;
    end else if (ch2_highpass_off) begin // RULE_06
      ch2_filter_enable <= 1'b0;
      ch2_highpass_setting <= adccal_pkg::HP_GLOBAL_OFF;
    end else begin // RULE_07
      ch2_filter_enable <= (global_highpass_setting != adccal_pkg::HP_GLOBAL_OFF);
      ch2_highpass_setting <= global_highpass_setting;
    end
  end

  // ==========================================================
  // Input path: bit 0 external, 1 shorted, 2 test +, 3 test -
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ch2_path_onehot <= 4'h1;
    end else begin
      case (adccal_pkg::adccal_sel_t'(ch2_input_select)) // RULE_08
        adccal_pkg::SEL_EXTERNAL: ch2_path_onehot <= 4'h1;
        adccal_pkg::SEL_SHORTED: ch2_path_onehot <= 4'h2;
        adccal_pkg::SEL_TEST_POS: ch2_path_onehot <= 4'h4;
        adccal_pkg::SEL_TEST_NEG: ch2_path_onehot <= 4'h8;
        default: ch2_path_onehot <= 4'h1;
      endcase
    end
  end

endmodule // adccal_ch2_route

// *** verification/adccal_regs_tb.sv ***
// Self-checking bench for the channel trim and setup register slice.
// Assumes the design package and modules are compiled first; the bench is the only bus master.
`timescale 1ns/10ps
module adccal_regs_tb;
  // ==========================================================
  // Signals
  logic aclk;
  logic aresetn;
  logic [7:0] awaddr;
  logic [2:0] awprot;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic [1:0] bresp;
  logic [7:0] araddr;
  logic [2:0] arprot;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic [3:0] global_highpass_setting;
  logic [23:0] ch1_gain_value;
  logic [23:0] ch2_offset_value;
  logic [15:0] ch2_gain_value_upper;
  logic [9:0] ch2_delay_trim;
  logic ch2_filter_enable;
  logic [3:0] ch2_highpass_setting;
  logic [3:0] ch2_path_onehot;
  int miscompares, cmp_count, k;
  logic [31:0] seed, rd;
  logic [15:0] model_q [0:5];
  logic [15:0] d;
  logic [3:0] s;
  logic [1:0] rsp;

  adccal_regs dut (.aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .global_highpass_setting, .ch1_gain_value, .ch2_offset_value, .ch2_gain_value_upper, .ch2_delay_trim,
    .ch2_filter_enable, .ch2_highpass_setting, .ch2_path_onehot);

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // ==========================================================
  // Expectation helpers
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [7:0] addr_of(input int n);
    return 8'h44 + 8'(4 * n);
  endfunction
  function automatic logic [15:0] merged(input logic [15:0] old, input logic [15:0] v, input logic [3:0] st,
    input int n);
    logic [15:0] lanes;
    lanes = {{8{st[1]}}, {8{st[0]}}} & ((n == 1 || n == 4) ? 16'hff00 : (n == 2) ? 16'hffc7 : 16'hffff);
    return (old & ~lanes) | (v & lanes);
  endfunction

  // ==========================================================
  // Compare and bus tasks
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t value got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t response got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [15:0] v, input logic [3:0] st, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {16'ha5a5, v};
    wstrb <= st;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 100);
    r = bresp;
    bready <= 1'b0;
    if (n >= 100) chk_val(32'h0, 32'h1);
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && n < 100);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 100) chk_val(32'h0, 32'h1);
  endtask
  task automatic chk_outputs;
    chk_val({8'h0, ch1_gain_value}, {8'h0, model_q[0], model_q[1][15:8]});
    chk_val({8'h0, ch2_offset_value}, {8'h0, model_q[3], model_q[4][15:8]});
    chk_val({16'h0, ch2_gain_value_upper}, {16'h0, model_q[5]});
    chk_val({22'h0, ch2_delay_trim}, {22'h0, model_q[2][15:6]});
    chk_val({27'h0, ch2_filter_enable, ch2_highpass_setting}, {27'h0, !model_q[2][2] &&
      global_highpass_setting != 4'h0, model_q[2][2] ? 4'h0 : global_highpass_setting});
    chk_val({28'h0, ch2_path_onehot}, {28'h0, 4'h1 << model_q[2][1:0]});
  endtask
  task automatic check_all_regs;
    for (int n = 0; n < 6; n++) begin
      axi_read(addr_of(n), rd, rsp);
      chk_val(rd, {16'h0, model_q[n]});
      chk_resp(rsp, 2'h0);
    end
  endtask
  task automatic summarize;
    if (miscompares == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    {aresetn, awaddr, awprot, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arprot, arvalid, rready, global_highpass_setting} = '0;
    miscompares = 0;
    cmp_count = 0;
    seed = 32'hc7e8;
    for (int n = 0; n < 6; n++) model_q[n] = (n == 0 || n == 5) ? 16'h8000 : 16'h0000;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    check_all_regs();
    chk_outputs();
    // Random writes with partial strobes, each read back
    for (int i = 0; i < 60; i++) begin
      repeat (16) seed = lfsr_next(seed);
      k = int'(seed[10:8]) % 6;
      d = seed[31:16];
      s = (i % 4 == 0) ? 4'hf : seed[3:0];
      global_highpass_setting <= seed[7:4];
      axi_write(addr_of(k), d, s, rsp);
      chk_resp(rsp, 2'h0);
      model_q[k] = merged(model_q[k], d, s, k);
      axi_read(addr_of(k), rd, rsp);
      chk_val(rd, {16'h0, model_q[k]});
      chk_outputs();
    end
    // Every select code and local filter bit, global setting 0 and 9, and delay extremes
    for (int i = 0; i < 16; i++) begin
      global_highpass_setting <= i[3] ? 4'h9 : 4'h0;
      d = {i[0] ? 10'h200 : 10'h1ff, 3'h7, i[2], i[1:0]};
      axi_write(addr_of(2), d, 4'h3, rsp);
      model_q[2] = merged(model_q[2], d, 4'h3, 2);
      axi_read(addr_of(2), rd, rsp);
      chk_val(rd, {16'h0, model_q[2]});
      chk_outputs();
      axi_read(8'h80, rd, rsp);
      chk_resp(rsp, 2'h0);
      chk_val(rd, {27'h0, !model_q[2][2] && global_highpass_setting != 4'h0,
        4'h1 << model_q[2][1:0]});
    end
    // Unmapped places are refused, a status write is answered OKAY, and none store anything
    axi_write(8'h5c, 16'hffff, 4'hf, rsp);
    chk_resp(rsp, 2'h2);
    axi_write(8'h00, 16'hffff, 4'hf, rsp);
    chk_resp(rsp, 2'h2);
    axi_read(8'h5c, rd, rsp);
    chk_resp(rsp, 2'h2);
    chk_val(rd, 32'h0);
    axi_write(8'h80, 16'hffff, 4'hf, rsp);
    chk_resp(rsp, 2'h0);
    check_all_regs();
    summarize();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    $display("ERROR %0t watchdog expired", $time);
    summarize();
  end
endmodule // adccal_regs_tb
